// file: and_file_and_carry_branch_exec.sv
// Four-phase executor for and_accumulator_with_file and branch_on_carry_set
// What this block does
// - AND instruction ANDs accumulator with the addressed byte, operand 0 to 255.
// - Destination bit 0 writes accumulator; 1 writes back to the data byte.
// - Access bit 0 uses the fixed access window; 1 uses bank_select_reg.
// - Access 0, extended enabled, operand at most 5Fh: indexed literal-offset address.
// - Branch-on-carry transfers control only when carry is 1.
// - Branch offset is signed -128 to 127, doubled before adding.
// - Taken branch loads instruction address plus 2 plus twice the offset.
// - Taken branch takes two cycles; the second does nothing in any phase.
`timescale 1ns/1ps
`include "core_consts.svh"
module and_file_and_carry_branch_exec
#(
    parameter int PC_W = 21
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Program side
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    output logic [PC_W-1:0] program_counter,
    // Core state from outside
    input wire logic carry,
    input wire logic ext_enable,
    input wire logic [5:0] bank_select_reg,
    input wire logic [13:0] index_base,
    // Data memory
    output logic [13:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    // Results and status
    output logic [7:0] accumulator,
    output logic flag_n,
    output logic flag_z,
    output core_pkg::phase_t phase,
    output logic cycle_idle
);
    generate
        if (PC_W < 9 || PC_W > 32)
        begin : g_bad_pc
            $error("PC_W must lie between 9 and 32");
        end
    endgenerate

    core_pkg::op_t op, next_op;
    core_pkg::phase_t next_phase;
    logic [15:0] instr_reg, next_instr_reg;
    logic [7:0] result, next_result;
    logic [7:0] next_accumulator, next_mem_wdata;
    logic [PC_W-1:0] next_program_counter, branch_target;
    logic [13:0] next_mem_addr, mapped_addr;
    logic next_mem_rd, next_mem_wr, next_flag_n, next_flag_z;
    logic skip, next_skip;

    operand_addr_map u_map
    (
        .file_addr(instr_reg[7:0]),
        .access_sel(instr_reg[`CORE_ACCESS_BIT]),
        .ext_enable(ext_enable),
        .bank_select_reg(bank_select_reg),
        .index_base(index_base),
        .data_addr(mapped_addr)
    );

    // The counter already points past the branch, so only 2n is added
    assign branch_target = program_counter
        + {{(PC_W-9){instr_reg[7]}}, instr_reg[7:0], 1'b0};
    assign cycle_idle = (op == core_pkg::OP_IDLE);

    always_comb
    begin
        next_phase = phase;
        next_op = op;
        next_instr_reg = instr_reg;
        next_result = result;
        next_accumulator = accumulator;
        next_program_counter = program_counter;
        next_mem_addr = mem_addr;
        next_mem_rd = 1'b0;
        next_mem_wr = 1'b0;
        next_mem_wdata = mem_wdata;
        next_flag_n = flag_n;
        next_flag_z = flag_z;
        next_skip = skip;
        case (phase)
            core_pkg::PH_Q1:
            begin
                next_phase = core_pkg::PH_Q2;
                if (skip)
                begin
                    // Flushed cycle after a taken branch: fetch is ignored
                    next_op = core_pkg::OP_IDLE;
                    next_skip = 1'b0;
                end
                else if (instr_valid)
                begin
                    next_instr_reg = instr;
                    next_program_counter = program_counter + PC_W'(`CORE_PC_STEP);
                    if (instr[15:10] == `CORE_OPC_AND)
                    begin
                        next_op = core_pkg::OP_AND;
                    end
                    else if (instr[15:8] == `CORE_OPC_BC)
                    begin
                        // Offset is read here; an untaken branch changes the counter only by this fetch increment
                        next_op = core_pkg::OP_BC;
                    end
                    else
                    begin
                        next_op = core_pkg::OP_NONE;
                    end
                end
                else
                begin
                    next_op = core_pkg::OP_NONE;
                end
            end
            core_pkg::PH_Q2:
            begin
                next_phase = core_pkg::PH_Q3;
                if (op == core_pkg::OP_AND)
                begin
                    next_mem_addr = mapped_addr;
                    next_mem_rd = 1'b1;
                end
            end
            core_pkg::PH_Q3:
            begin
                next_phase = core_pkg::PH_Q4;
                if (op == core_pkg::OP_AND)
                begin
                    next_result = accumulator & mem_rdata;
                end
            end
            core_pkg::PH_Q4:
            begin
                next_phase = core_pkg::PH_Q1;
                if (op == core_pkg::OP_AND)
                begin
                    if (instr_reg[`CORE_DEST_BIT])
                    begin
                        next_mem_wr = 1'b1;
                        next_mem_wdata = result;
                    end
                    else
                    begin
                        next_accumulator = result;
                    end
                    next_flag_n = result[7];
                    next_flag_z = (result == 8'h00);
                end
                else if (op == core_pkg::OP_BC && carry)
                begin
                    next_program_counter = branch_target;
                    next_skip = 1'b1;
                end
            end
            default:
            begin
                next_phase = core_pkg::PH_Q1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            phase <= core_pkg::PH_Q1;
            op <= core_pkg::OP_NONE;
            instr_reg <= 16'h0000;
            result <= `CORE_DATA_RESET;
            accumulator <= `CORE_ACC_RESET;
            program_counter <= '0;
            mem_addr <= `CORE_ADDR_RESET;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= `CORE_DATA_RESET;
            flag_n <= 1'b0;
            flag_z <= 1'b0;
            skip <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            op <= next_op;
            instr_reg <= next_instr_reg;
            result <= next_result;
            accumulator <= next_accumulator;
            program_counter <= next_program_counter;
            mem_addr <= next_mem_addr;
            mem_rd <= next_mem_rd;
            mem_wr <= next_mem_wr;
            mem_wdata <= next_mem_wdata;
            flag_n <= next_flag_n;
            flag_z <= next_flag_z;
            skip <= next_skip;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic q4_and, q4_taken, q4_not_taken;
    logic [13:0] index_sum;
    assign q4_and = (phase == core_pkg::PH_Q4) && (op == core_pkg::OP_AND);
    assign q4_taken = (phase == core_pkg::PH_Q4) && (op == core_pkg::OP_BC) && carry;
    assign q4_not_taken = (phase == core_pkg::PH_Q4) && (op == core_pkg::OP_BC) && !carry;
    assign index_sum = index_base + {6'h00, instr_reg[7:0]};

    sequence and_decoded;
        (phase == core_pkg::PH_Q1) && !skip && instr_valid && (instr[15:10] == `CORE_OPC_AND);
    endsequence
    sequence and_bus_steps;
        !mem_rd ##1 mem_rd ##1 !mem_rd ##1 (mem_wr == $past(instr_reg[`CORE_DEST_BIT], 1));
    endsequence
    sequence idle_cycle;
        (cycle_idle && !mem_rd && !mem_wr && $stable(program_counter))[*4];
    endsequence

    AST_AND_RESULT:
    assert property (mem_rd |=> result == ($past(accumulator) & $past(mem_rdata)))
        else $error("AND result does not match operands");
    AST_DEST_ACC:
    assert property (q4_and && !instr_reg[`CORE_DEST_BIT]
        |=> accumulator == $past(result) && !mem_wr)
        else $error("Destination 0 did not update accumulator");
    AST_DEST_FILE:
    assert property (q4_and && instr_reg[`CORE_DEST_BIT]
        |=> mem_wr && mem_wdata == $past(result) && $stable(accumulator))
        else $error("Destination 1 did not write memory");
    AST_BANKED_ADDR:
    assert property ((phase == core_pkg::PH_Q2) && (op == core_pkg::OP_AND)
        && instr_reg[`CORE_ACCESS_BIT]
        |=> mem_addr == {$past(bank_select_reg), $past(instr_reg[7:0])})
        else $error("Banked address wrong");
    AST_INDEXED_ADDR:
    assert property ((phase == core_pkg::PH_Q2) && (op == core_pkg::OP_AND)
        && !instr_reg[`CORE_ACCESS_BIT] && ext_enable && instr_reg[7:0] <= `CORE_LITOFS_MAX
        |=> mem_addr == $past(index_sum))
        else $error("Indexed literal-offset address wrong");
    AST_BRANCH_TARGET:
    assert property (q4_taken |=> program_counter == $past(program_counter)
        + {{(PC_W-9){$past(instr_reg[7])}}, $past(instr_reg[7:0]), 1'b0})
        else $error("Taken branch target wrong");
    AST_BRANCH_IDLE:
    assert property (q4_taken |=> ##1 idle_cycle)
        else $error("Taken branch not followed by an idle cycle");
    AST_NOT_TAKEN:
    assert property (q4_not_taken |=> $stable(program_counter) ##1 !cycle_idle)
        else $error("Untaken branch changed flow");
    AST_AND_TIMING:
    assert property (and_decoded |=> and_bus_steps)
        else $error("AND did not complete in one cycle");
    AST_AND_FLAGS:
    assert property (q4_and |=> flag_z == ($past(result) == 8'h00)
        && flag_n == $past(result[7]))
        else $error("Flags not updated from result");
    AST_BC_NO_MEM:
    assert property (op == core_pkg::OP_BC |-> !mem_rd && !mem_wr)
        else $error("Branch touched data memory");
endmodule // and_file_and_carry_branch_exec

// file: and_file_and_carry_branch_exec_test.sv
// Self-checking bench for the AND-with-file and branch-on-carry executor
`timescale 1ns/1ps
module and_file_and_carry_branch_exec_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic instr_valid = 1'b0;
    logic carry = 1'b0;
    logic ext_enable = 1'b0;
    logic [5:0] bank_select_reg = 6'h12;
    logic [13:0] index_base = 14'h0100;
    logic [20:0] program_counter;
    logic [13:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_rdata;
    logic [7:0] mem_wdata;
    logic [7:0] accumulator;
    logic flag_n;
    logic flag_z;
    logic cycle_idle;
    core_pkg::phase_t phase;
    int fails = 0;
    int num_checks = 0;

    always #25 clk = ~clk;

    and_file_and_carry_branch_exec dut (.clk(clk), .resetn(resetn), .instr(instr),
        .instr_valid(instr_valid), .program_counter(program_counter), .carry(carry),
        .ext_enable(ext_enable), .bank_select_reg(bank_select_reg), .index_base(index_base),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .accumulator(accumulator), .flag_n(flag_n), .flag_z(flag_z),
        .phase(phase), .cycle_idle(cycle_idle));

    data_mem_model mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata));

    task automatic finish_test;
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Leaves the caller in a Q4 cycle so the next edge starts a Q1 cycle
    task automatic wait_q4;
        int k;
        k = 0;
        @(negedge clk);
        while (phase !== core_pkg::PH_Q4 && k < 8)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 8)
        begin
            fails++;
            finish_test();
        end
    endtask

    task automatic and_case(input logic d, input logic a, input logic [7:0] f,
        input logic ext, input logic [13:0] exp_addr);
        logic [13:0] seen_addr;
        logic seen_rd;
        mem.ram[exp_addr] = 8'hFF;
        wait_q4();
        @(posedge clk);
        instr <= {6'h05, d, a, f};
        instr_valid <= 1'b1;
        ext_enable <= ext;
        @(posedge clk);
        instr_valid <= 1'b0;
        // The read strobe stands only in the cycle after the Q2 edge
        @(posedge clk);
        #1;
        seen_addr = mem_addr;
        seen_rd = mem_rd;
        repeat (2) @(posedge clk);
        #1;
        cmp("mem_addr", exp_addr, seen_addr);
        cmp("mem_rd", 1'b1, seen_rd);
        cmp("mem_wr", d, mem_wr);
        cmp("flag_z", 1'b1, flag_z);
        cmp("flag_n", 1'b0, flag_n);
        cmp("accumulator", 8'h00, accumulator);
        @(posedge clk);
        #1;
        cmp("data byte", d ? 8'h00 : 8'hFF, mem.ram[exp_addr]);
    endtask

    task automatic branch_case(input logic [7:0] n, input logic c);
        logic [20:0] a;
        logic [20:0] exp_pc;
        int k;
        wait_q4();
        a = program_counter;
        // Not taken: the following no-op at the next Q1 is accepted and adds 2
        exp_pc = c ? a + 21'h000002 + {{12{n[7]}}, n, 1'b0} : a + 21'h000004;
        @(posedge clk);
        instr <= {8'hE2, n};
        instr_valid <= 1'b1;
        carry <= c;
        @(posedge clk);
        instr <= 16'h0000;
        #1;
        cmp("pc after fetch", a + 21'h000002, program_counter);
        repeat (4) @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        cmp("pc after branch", exp_pc, program_counter);
        for (k = 0; k < 3; k++)
        begin
            @(posedge clk);
            #1;
            cmp("cycle_idle", c, cycle_idle);
            cmp("mem_rd idle", 1'b0, mem_rd);
        end
        cmp("pc held", exp_pc, program_counter);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        #1;
        cmp("phase", core_pkg::PH_Q1, phase);
        cmp("pc reset", 21'h000000, program_counter);
        and_case(1'b1, 1'b1, 8'hA5, 1'b0, 14'h12A5);
        and_case(1'b1, 1'b0, 8'h10, 1'b0, 14'h0010);
        and_case(1'b1, 1'b0, 8'h60, 1'b0, 14'h3F60);
        and_case(1'b1, 1'b0, 8'h5F, 1'b1, 14'h015F);
        and_case(1'b1, 1'b0, 8'h60, 1'b1, 14'h3F60);
        and_case(1'b1, 1'b1, 8'h20, 1'b1, 14'h1220);
        and_case(1'b0, 1'b1, 8'h33, 1'b0, 14'h1233);
        branch_case(8'h05, 1'b0);
        branch_case(8'h05, 1'b1);
        branch_case(8'h80, 1'b1);
        branch_case(8'h7F, 1'b1);
        branch_case(8'h80, 1'b0);
        finish_test();
    end
endmodule // and_file_and_carry_branch_exec_test

// file: core_consts.svh
// Constants for the AND-with-file and branch-on-carry execution block
`ifndef CORE_CONSTS_SVH
`define CORE_CONSTS_SVH
`define CORE_OPC_AND 6'h05
`define CORE_OPC_BC 8'hE2
`define CORE_DEST_BIT 9
`define CORE_ACCESS_BIT 8
`define CORE_ACCESS_SPLIT 8'h60
`define CORE_LITOFS_MAX 8'h5F
`define CORE_LOW_BANK 6'h00
`define CORE_HIGH_BANK 6'h3F
`define CORE_BANK_W 6
`define CORE_DATA_ADDR_W 14
`define CORE_PC_STEP 2
`define CORE_ACC_RESET 8'h00
`define CORE_DATA_RESET 8'h00
`define CORE_ADDR_RESET 14'h0000
`endif

// file: core_pkg.sv
// Types shared by the execution block
package core_pkg;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
    typedef enum logic [1:0] {OP_NONE, OP_AND, OP_BC, OP_IDLE} op_t;
endpackage

// file: data_mem_model.sv
// Behavioural data memory on the far side of the executor
`timescale 1ns/1ps
module data_mem_model
(
    // Clock
    input wire logic clk,
    // Data memory bus
    input wire logic [13:0] mem_addr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata
);
    logic [7:0] ram [0:16383];
    logic [7:0] last = 8'h00;
    // Off a read the bus shows the inverse of the last byte, so stale data never matches
    assign mem_rdata = mem_rd ? ram[mem_addr] : ~last;
    always @(posedge clk)
    begin
        if (mem_rd)
            last <= ram[mem_addr];
        if (mem_wr)
            ram[mem_addr] <= mem_wdata;
    end
endmodule // data_mem_model

// file: operand_addr_map.sv
// Data address selection for byte-oriented operands
`timescale 1ns/1ps
`include "core_consts.svh"
module operand_addr_map
(
    // Operand fields
    input wire logic [7:0] file_addr,
    input wire logic access_sel,
    input wire logic ext_enable,
    // Address sources
    input wire logic [5:0] bank_select_reg,
    input wire logic [13:0] index_base,
    // Result
    output logic [13:0] data_addr
);
    always_comb
    begin
        if (!access_sel && ext_enable && file_addr <= `CORE_LITOFS_MAX)
        begin
            data_addr = index_base + {6'h00, file_addr};
        end
        else if (access_sel)
        begin
            data_addr = {bank_select_reg, file_addr};
        end
        else if (file_addr < `CORE_ACCESS_SPLIT)
        begin
            data_addr = {`CORE_LOW_BANK, file_addr};
        end
        else
        begin
            data_addr = {`CORE_HIGH_BANK, file_addr};
        end
    end
endmodule // operand_addr_map
